// file: hdl/aspm_mux.sv
// pin mux for shared audio / serial / codec pins plus port d and port e sharing
`default_nettype none
`include "aspm_defs.svh"
module aspm_mux (
	input  wire logic                  clk_i,
	input  wire logic                  rst_i,
	// selection bits from the system control registers
	input  wire logic                  serial_port_select_bit_i,
	input  wire logic                  audio_port_select_bit_i,
	// function sides
	input  wire aspm_pkg::aspm_fn_out_t audio_out_i,
	input  wire aspm_pkg::aspm_fn_out_t serial_out_i,
	input  wire aspm_pkg::aspm_fn_out_t codec_out_i,
	input  wire logic                  audio_master_clock_out_i,
	output aspm_pkg::aspm_fn_in_t      audio_in_o,
	output aspm_pkg::aspm_fn_in_t      serial_in_o,
	output aspm_pkg::aspm_fn_in_t      codec_in_o,
	// shared serial pins
	input  wire logic                  shared_bit_clock_pin_i,
	output logic                       shared_bit_clock_pin_o,
	output logic                       shared_bit_clock_pin_oe_o,
	output logic                       shared_tx_data_pin_o,
	input  wire logic                  shared_rx_data_pin_i,
	input  wire logic                  shared_tx_frame_pin_i,
	output logic                       shared_tx_frame_pin_o,
	output logic                       shared_tx_frame_pin_oe_o,
	input  wire logic                  shared_rx_frame_pin_i,
	output logic                       buzzer_output_pin_o,
	// port d bit zero / led blink
	input  wire logic                  led_blink_enable_i,
	input  wire logic                  led_blink_output_i,
	input  wire logic                  port_d_bit_zero_out_i,
	input  wire logic                  port_d_bit_zero_oe_i,
	output logic                       port_d_bit_zero_pin_o,
	output logic                       port_d_bit_zero_pin_oe_o,
	// port d bits 7:6 / sdram byte masks
	input  wire logic                  sdram_mask_enable_i,
	input  wire logic [1:0]            sdram_byte_masks_i,
	input  wire logic [1:0]            port_d_hi_out_i,
	input  wire logic [1:0]            port_d_hi_oe_i,
	output logic      [1:0]            port_d_hi_pin_o,
	output logic      [1:0]            port_d_hi_pin_oe_o,
	// port e bits 2:0 / strap inputs
	input  wire logic [2:0]            port_e_pin_i,
	output logic      [2:0]            port_e_data_o,
	output logic      [1:0]            boot_select_inputs_o,
	output logic                       clock_source_select_input_o,
	output logic      [1:0]            owner_o
);
	aspm_pkg::aspm_owner_t owner;
	aspm_pkg::aspm_fn_out_t sel_out;
	aspm_pkg::aspm_fn_in_t  pins_in;
	aspm_pkg::aspm_fn_in_t  idle_in;
	logic [3:0]             pin_raw;
	logic [3:0]             pin_sync;
	logic [2:0]             port_e_sync;
	logic                   strap_taken_ff;
	logic [2:0]             strap_wait_ff;

	// owner decode: audio bit wins, then serial bit picks serial or codec
	always_comb begin
		if (audio_port_select_bit_i == `ASPM_SEL_AUDIO) begin
			owner = aspm_pkg::ASPM_OWN_AUDIO;
		end else if (serial_port_select_bit_i == `ASPM_SEL_CODEC) begin
			owner = aspm_pkg::ASPM_OWN_CODEC;
		end else begin
			owner = aspm_pkg::ASPM_OWN_SERIAL;
		end
	end

	// single owner's outputs chosen; the other two never reach a pin
	always_comb begin
		case (owner)
			aspm_pkg::ASPM_OWN_AUDIO:  sel_out = audio_out_i;
			aspm_pkg::ASPM_OWN_CODEC:  sel_out = codec_out_i;
			aspm_pkg::ASPM_OWN_SERIAL: sel_out = serial_out_i;
			default:                   sel_out = serial_out_i;
		endcase
	end

	// pin inputs are asynchronous to clk_i, so they go through the filter
	assign pin_raw = {shared_bit_clock_pin_i, shared_rx_data_pin_i, shared_tx_frame_pin_i, shared_rx_frame_pin_i};

	aspm_sync #(.WIDTH(4), .INIT(`ASPM_IN_IDLE)) u_pin_sync (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.pin_i  (pin_raw),
		.sync_o (pin_sync)
	);

	aspm_sync #(.WIDTH(3), .INIT(3'h0)) u_port_e_sync (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.pin_i  (port_e_pin_i),
		.sync_o (port_e_sync)
	);

	assign pins_in.clk_in   = pin_sync[3];
	assign pins_in.rx_data  = pin_sync[2];
	assign pins_in.frame_in = pin_sync[1];
	assign pins_in.rx_frame = pin_sync[0];
	// idle levels: clocks and data low, the unused rx frame line reads as pulled up
	assign idle_in.clk_in   = `ASPM_IDLE_LOW;
	assign idle_in.rx_data  = `ASPM_IDLE_LOW;
	assign idle_in.frame_in = `ASPM_IDLE_LOW;
	assign idle_in.rx_frame = `ASPM_IDLE_HIGH;

	// shared pin drive, registered so every output leaves a flip-flop
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			shared_bit_clock_pin_o    <= `ASPM_IDLE_LOW;
			shared_bit_clock_pin_oe_o <= `ASPM_IDLE_LOW;
			shared_tx_data_pin_o      <= `ASPM_IDLE_LOW;
			shared_tx_frame_pin_o     <= `ASPM_IDLE_LOW;
			shared_tx_frame_pin_oe_o  <= `ASPM_IDLE_LOW;
			buzzer_output_pin_o       <= `ASPM_IDLE_LOW;
			owner_o                   <= 2'h0;
		end else begin
			shared_bit_clock_pin_o    <= sel_out.clk_out;
			shared_bit_clock_pin_oe_o <= sel_out.clk_oe;
			shared_tx_data_pin_o      <= sel_out.tx_data;
			shared_tx_frame_pin_o     <= sel_out.frame_out;
			shared_tx_frame_pin_oe_o  <= sel_out.frame_oe;
			// buzzer carries the master clock only in audio mode
			buzzer_output_pin_o <= (owner == aspm_pkg::ASPM_OWN_AUDIO) ? audio_master_clock_out_i
				: `ASPM_IDLE_LOW;
			owner_o <= owner;
		end
	end

	// pin inputs reach only the owner; the rest see idle constants
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			audio_in_o  <= `ASPM_IN_IDLE;
			serial_in_o <= `ASPM_IN_IDLE;
			codec_in_o  <= `ASPM_IN_IDLE;
		end else begin
			audio_in_o  <= (owner == aspm_pkg::ASPM_OWN_AUDIO)  ? pins_in : idle_in;
			serial_in_o <= (owner == aspm_pkg::ASPM_OWN_SERIAL) ? pins_in : idle_in;
			// codec has no use for the rx frame line, which stays at its pull-up level
			codec_in_o  <= (owner == aspm_pkg::ASPM_OWN_CODEC)
				? {pins_in.clk_in, pins_in.rx_data, pins_in.frame_in, `ASPM_IDLE_HIGH} : idle_in;
		end
	end

	// port d bit zero is either gpio or led blink, never a blend
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			port_d_bit_zero_pin_o    <= `ASPM_IDLE_LOW;
			port_d_bit_zero_pin_oe_o <= `ASPM_IDLE_LOW;
		end else if (led_blink_enable_i) begin
			port_d_bit_zero_pin_o    <= led_blink_output_i;
			port_d_bit_zero_pin_oe_o <= `ASPM_IDLE_HIGH;
		end else begin
			port_d_bit_zero_pin_o    <= port_d_bit_zero_out_i;
			port_d_bit_zero_pin_oe_o <= port_d_bit_zero_oe_i;
		end
	end

	// port d bits 7:6 give way to the sdram byte masks when the sdram uses them
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			port_d_hi_pin_o    <= 2'h0;
			port_d_hi_pin_oe_o <= 2'h0;
		end else if (sdram_mask_enable_i) begin
			port_d_hi_pin_o    <= sdram_byte_masks_i;
			port_d_hi_pin_oe_o <= `ASPM_PAIR_ALL;
		end else begin
			port_d_hi_pin_o    <= port_d_hi_out_i;
			port_d_hi_pin_oe_o <= port_d_hi_oe_i;
		end
	end

	// port e reads live; the straps are caught once, but only after the synchroniser has
	// flushed its reset value, otherwise the straps would always read as zero
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			port_e_data_o               <= 3'h0;
			boot_select_inputs_o        <= 2'h0;
			clock_source_select_input_o <= `ASPM_IDLE_LOW;
			strap_taken_ff              <= `ASPM_IDLE_LOW;
			strap_wait_ff               <= 3'h0;
		end else begin
			port_e_data_o <= port_e_sync;
			if (!strap_taken_ff) begin
				if (strap_wait_ff == `ASPM_STRAP_SETTLE) begin
					boot_select_inputs_o        <= port_e_sync[1:0];
					clock_source_select_input_o <= port_e_sync[2];
					strap_taken_ff              <= `ASPM_IDLE_HIGH;
				end else begin
					strap_wait_ff <= strap_wait_ff + 3'h1; // settle count
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: hdl/aspm_sync.sv
// three-stage pin synchroniser with agreement filter
`default_nettype none
`include "aspm_defs.svh"
module aspm_sync #(
	parameter int          WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] pin_i,
	output logic      [WIDTH-1:0] sync_o
);
	logic [WIDTH-1:0] meta_ff;
	logic [WIDTH-1:0] s2_ff;
	logic [WIDTH-1:0] s3_ff;
	// first stage is read only by the second stage
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_ff <= INIT;
			s2_ff   <= INIT;
			s3_ff   <= INIT;
		end else begin
			meta_ff <= pin_i;
			s2_ff   <= meta_ff;
			s3_ff   <= s2_ff;
		end
	end
	// a bit changes only once stages two and three agree, so one-cycle glitches are ignored
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sync_o <= INIT;
		end else begin
			for (int i = 0; i < WIDTH; i++) begin
				if (s2_ff[i] == s3_ff[i]) begin
					sync_o[i] <= s3_ff[i];
				end
			end
		end
	end
endmodule
`default_nettype wire

// file: shared/aspm_defs.svh
// constant definitions for the audio serial pin mux
`ifndef ASPM_DEFS_SVH
`define ASPM_DEFS_SVH
`define ASPM_IDLE_LOW    1'h0
`define ASPM_IDLE_HIGH   1'h1
`define ASPM_SEL_AUDIO   1'h1
`define ASPM_SEL_CODEC   1'h1
`define ASPM_SYNC_DEPTH  3
// function input word at rest: clock, data and frame low, rx frame at its pull-up level
`define ASPM_IN_IDLE     4'h1
// both upper port d bits driven
`define ASPM_PAIR_ALL    2'h3
// edges after reset release before the port e synchroniser holds real pin values
`define ASPM_STRAP_SETTLE 3'h4
`endif

// file: shared/aspm_pkg.sv
// types shared by the audio serial pin mux
`default_nettype none
package aspm_pkg;
	typedef enum logic [1:0] {
		ASPM_OWN_SERIAL,
		ASPM_OWN_CODEC,
		ASPM_OWN_AUDIO
	} aspm_owner_t;
	// one function's view of the shared serial group, towards the pins
	typedef struct packed {
		logic clk_out;
		logic clk_oe;
		logic tx_data;
		logic frame_out;
		logic frame_oe;
	} aspm_fn_out_t;
	// one function's view of the shared serial group, from the pins
	typedef struct packed {
		logic clk_in;
		logic rx_data;
		logic frame_in;
		logic rx_frame;
	} aspm_fn_in_t;
endpackage
`default_nettype wire

// file: tb/aspm_peer.sv
// far-side serial peripheral model on the shared pins
`default_nettype none
module aspm_peer (
	input  wire logic       rel_i,
	input  wire logic [3:0] lvl_i,
	input  wire logic       bc_i,
	input  wire logic       bc_oe_i,
	input  wire logic       fr_i,
	input  wire logic       fr_oe_i,
	output logic            bc_o,
	output logic            fr_o,
	output logic            rxd_o,
	output logic            rfr_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// a two-way pin shows the device level only while the device drives it
	assign bc_o  = bc_oe_i ? bc_i : lvl_i[3];
	assign fr_o  = fr_oe_i ? fr_i : lvl_i[1];
	assign rxd_o = lvl_i[2];
	// a released frame line falls to its pull-up level
	assign rfr_o = rel_i ? 1'h1 : lvl_i[0];
endmodule
`default_nettype wire

// file: tb/aspm_properties.sv
// port-level assertions for the audio serial pin mux
`default_nettype none
module aspm_properties (
	input wire logic                   clk_i,
	input wire logic                   rst_i,
	input wire logic                   serial_port_select_bit_i,
	input wire logic                   audio_port_select_bit_i,
	input wire aspm_pkg::aspm_fn_out_t audio_out_i,
	input wire aspm_pkg::aspm_fn_out_t serial_out_i,
	input wire aspm_pkg::aspm_fn_out_t codec_out_i,
	input wire logic                   audio_master_clock_out_i,
	input wire aspm_pkg::aspm_fn_in_t  audio_in_o,
	input wire aspm_pkg::aspm_fn_in_t  codec_in_o,
	input wire logic                   shared_bit_clock_pin_o,
	input wire logic                   shared_bit_clock_pin_oe_o,
	input wire logic                   shared_tx_data_pin_o,
	input wire logic                   shared_tx_frame_pin_o,
	input wire logic                   shared_tx_frame_pin_oe_o,
	input wire logic                   shared_rx_data_pin_i,
	input wire logic                   buzzer_output_pin_o,
	input wire logic [1:0]             owner_o
);
	timeunit 1ns;
	timeprecision 1ps;
	aspm_pkg::aspm_fn_out_t sel;
	logic [1:0]             own;
	// expected owner: the audio bit wins, then the serial bit picks
	assign own = audio_port_select_bit_i ? 2'h2 : {1'h0, serial_port_select_bit_i};
	assign sel = own[1] ? audio_out_i : (own[0] ? codec_out_i : serial_out_i);
	default clocking cb @(posedge clk_i);
	endclocking
	// outputs lag their cause by one edge, so the edge after reset is skipped
	default disable iff (rst_i);
	chk_owner_code: assert property (!$past(rst_i) |-> owner_o == $past(own)) else $error("owner");
	chk_bit_clock: assert property (!$past(rst_i) |->
		{shared_bit_clock_pin_o, shared_bit_clock_pin_oe_o} == $past(sel[4:3])) else $error("bit clock");
	chk_tx_data: assert property (!$past(rst_i) |-> shared_tx_data_pin_o == $past(sel[2])) else $error("tx");
	chk_tx_frame: assert property (!$past(rst_i) |->
		{shared_tx_frame_pin_o, shared_tx_frame_pin_oe_o} == $past(sel[1:0])) else $error("frame");
	chk_buzzer_audio: assert property (!$past(rst_i) |->
		buzzer_output_pin_o == $past(own[1] & audio_master_clock_out_i)) else $error("buzzer");
	chk_audio_idle: assert property ((owner_o != 2'h2) [*6] |-> audio_in_o == 4'h1) else $error("idle");
	chk_codec_pullup: assert property (codec_in_o.rx_frame == 1'h1) else $error("codec rx frame");
	chk_rx_data: assert property ((owner_o == 2'h2 && $stable(shared_rx_data_pin_i)) [*7] |->
		audio_in_o.rx_data == shared_rx_data_pin_i) else $error("rx data");
	cover property (owner_o == 2'h1);
	cover property (buzzer_output_pin_o);
	cover property (owner_o == 2'h2 ##1 owner_o == 2'h0);
endmodule
bind aspm_mux aspm_properties chk (.*);
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the audio serial pin mux
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'h0, rst_i = 1'h1, serial_port_select_bit_i = 1'h0, audio_port_select_bit_i = 1'h0;
	logic audio_master_clock_out_i = 1'h0, led_blink_enable_i = 1'h0, led_blink_output_i = 1'h0;
	logic port_d_bit_zero_out_i = 1'h0, port_d_bit_zero_oe_i = 1'h0, sdram_mask_enable_i = 1'h0, p_rel = 1'h0;
	aspm_pkg::aspm_fn_out_t audio_out_i = '0, serial_out_i = '0, codec_out_i = '0;
	aspm_pkg::aspm_fn_in_t audio_in_o, serial_in_o, codec_in_o;
	logic shared_bit_clock_pin_i, shared_bit_clock_pin_o, shared_bit_clock_pin_oe_o, shared_tx_data_pin_o;
	logic shared_rx_data_pin_i, shared_tx_frame_pin_i, shared_tx_frame_pin_o, shared_tx_frame_pin_oe_o;
	logic shared_rx_frame_pin_i, buzzer_output_pin_o, port_d_bit_zero_pin_o, port_d_bit_zero_pin_oe_o;
	logic clock_source_select_input_o;
	logic [1:0] sdram_byte_masks_i = 2'h0, port_d_hi_out_i = 2'h0, port_d_hi_oe_i = 2'h0;
	logic [1:0] port_d_hi_pin_o, port_d_hi_pin_oe_o, boot_select_inputs_o, owner_o;
	logic [2:0] port_e_pin_i = 3'h5, port_e_data_o;
	logic [3:0] p_lvl = 4'h0;
	int num_errors = 0, n_compared = 0;
	aspm_mux uut (.*);
	aspm_peer peer (.rel_i(p_rel), .lvl_i(p_lvl), .bc_i(shared_bit_clock_pin_o), .bc_oe_i(shared_bit_clock_pin_oe_o),
		.fr_i(shared_tx_frame_pin_o), .fr_oe_i(shared_tx_frame_pin_oe_o), .bc_o(shared_bit_clock_pin_i),
		.fr_o(shared_tx_frame_pin_i), .rxd_o(shared_rx_data_pin_i), .rfr_o(shared_rx_frame_pin_i));
	initial begin
		forever #12.5 clk_i = ~clk_i;
	end
	task automatic cmp(string n, logic [11:0] e, logic [11:0] g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic do_reset();
		@(posedge clk_i);
		rst_i <= 1'h1;
		repeat (6) @(posedge clk_i);
		rst_i <= 1'h0;
	endtask
	task automatic set_mode(int m);
		audio_port_select_bit_i <= (m == 2);
		serial_port_select_bit_i <= (m == 1);
	endtask
	// straps are caught once per reset; later pin moves only reach the port
	task automatic t_strap();
		cmp("straps", 12'h5, {clock_source_select_input_o, boot_select_inputs_o});
		@(posedge clk_i);
		port_e_pin_i <= 3'h2;
		repeat (8) @(posedge clk_i);
		#1;
		cmp("port_e", 12'h2, port_e_data_o);
		cmp("straps", 12'h5, {clock_source_select_input_o, boot_select_inputs_o});
		do_reset();
		// straps settle only after the synchroniser has flushed, five edges after release
		repeat (6) @(posedge clk_i);
		#1;
		cmp("straps", 12'h2, {clock_source_select_input_o, boot_select_inputs_o});
	endtask
	// owner drives all ones or zeros, the others the inverse
	task automatic t_modes();
		for (int m = 0; m < 3; m++) begin
			for (int p = 0; p < 2; p++) begin
				@(posedge clk_i);
				set_mode(m);
				audio_master_clock_out_i <= p[0];
				audio_out_i <= {5{p[0] ^ (m != 2)}};
				serial_out_i <= {5{p[0] ^ (m != 0)}};
				codec_out_i <= {5{p[0] ^ (m != 1)}};
				repeat (2) @(posedge clk_i);
				#1;
				cmp("owner", m, owner_o);
				cmp("pins", {5{p[0]}}, {shared_bit_clock_pin_o, shared_bit_clock_pin_oe_o, shared_tx_data_pin_o,
					shared_tx_frame_pin_o, shared_tx_frame_pin_oe_o});
				cmp("buzzer", (m == 2) && p[0], buzzer_output_pin_o);
			end
		end
	endtask
	// pins reach only the owner; codec frame line is released to its pull-up
	task automatic t_inputs();
		logic [11:0] e;
		for (int m = 0; m < 3; m++) begin
			@(posedge clk_i);
			set_mode(m);
			{audio_out_i, serial_out_i, codec_out_i} <= '0;
			p_rel <= (m == 1);
			p_lvl <= 4'hC;
			repeat (8) @(posedge clk_i);
			#1;
			e = {3{4'h1}};
			e[4 * (m == 0 ? 1 : (m == 1 ? 0 : 2)) +: 4] = (m == 1) ? 4'hD : 4'hC;
			cmp("inputs", e, {audio_in_o, serial_in_o, codec_in_o});
		end
	endtask
	task automatic t_portd();
		logic [1:0] k;
		logic [5:0] e;
		for (int i = 0; i < 4; i++) begin
			k = i[1:0];
			@(posedge clk_i);
			// led level and gpio level differ, so a blend or a wrong pick shows
			{led_blink_enable_i, led_blink_output_i, port_d_bit_zero_out_i, port_d_bit_zero_oe_i} <= {k[0], k[1], ~k[1], k[1]};
			{sdram_mask_enable_i, sdram_byte_masks_i, port_d_hi_out_i, port_d_hi_oe_i} <= {k[1], k, ~k, k[0], k[1]};
			repeat (2) @(posedge clk_i);
			#1;
			e = {k[0] ? k[1] : ~k[1], k[0] | k[1], k[1] ? k : ~k, k[1] ? 2'h3 : {k[0], k[1]}};
			cmp("port_d", e, {port_d_bit_zero_pin_o, port_d_bit_zero_pin_oe_o, port_d_hi_pin_o, port_d_hi_pin_oe_o});
		end
	endtask
	task automatic summarize();
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	initial begin
		do_reset();
		repeat (6) @(posedge clk_i);
		#1;
		t_strap();
		t_modes();
		t_inputs();
		t_portd();
		summarize();
	end
	// a hang still reaches the verdict
	initial begin
		#1ms;
		num_errors++;
		summarize();
	end
endmodule
`default_nettype wire
